// ===== design/cpr_pkg.sv
// constants for the core status and power register bank
package cpr_pkg;
   // register indices on the register port
   localparam logic [3:0] ADDR_INDIRECT = 4'h0;
   localparam logic [3:0] ADDR_TIMER    = 4'h1;
   localparam logic [3:0] ADDR_PC       = 4'h2;
   localparam logic [3:0] ADDR_STATUS   = 4'h3;
   localparam logic [3:0] ADDR_RAMSEL   = 4'h4;
   localparam logic [3:0] ADDR_PAGE     = 4'h5;
   localparam logic [3:0] ADDR_LINE     = 4'ha;

   // core status fields
   localparam int ST_CARRY   = 0;
   localparam int ST_NIBBLE  = 1;
   localparam int ST_ZERO    = 2;
   localparam int ST_PWRDN   = 3;
   localparam int ST_TIMEOUT = 4;
   localparam int ST_IOPAGE  = 6;

   // ram select fields
   localparam int RS_IDX_W  = 6;
   localparam int RS_BANK_W = 2;

   // page select width
   localparam int PAGE_W = 4;

   // line status fields
   localparam int LN_RING    = 0;
   localparam int LN_CARRIER = 1;
   localparam int LN_DATA    = 2;
   localparam int LN_DEMODPW = 3;
   localparam int LN_LOWSUP  = 4;
   localparam int LN_LSDEN   = 5;
   localparam int LN_FASTCLK = 6;
   localparam int LN_IDLESEL = 7;
   localparam logic [7:0] LINE_RW_MASK = 8'he8;

   // program counter shape
   localparam int PC_W    = 14;
   localparam int PC_LO_W = 10;
   localparam int STACK_D = 8;
   localparam int SP_W    = 3;

   // reset values and timer maximum
   localparam logic [7:0]      TIMER_RST  = 8'h00;
   localparam logic [PC_W-1:0] PC_RST     = 14'h0000;
   localparam logic [7:0]      RAMSEL_RST = 8'h00;
   localparam logic [3:0]      PAGE_RST   = 4'h0;
   localparam logic [7:0]      LINE_RST   = 8'h40;
   localparam logic [7:0]      TIMER_MAX  = 8'hff;

   // program counter operations from the sequencer
   typedef enum logic [2:0] {
      PC_HOLD = 3'h0,
      PC_STEP = 3'h1,
      PC_JUMP = 3'h2,
      PC_CALL = 3'h3,
      PC_RET  = 3'h4,
      PC_MOVA = 3'h5,
      PC_ADDA = 3'h6,
      PC_TABLE = 3'h7
   } cpr_pcop_t;

   // low-power state, one-hot
   typedef enum logic [2:0] {
      MODE_RUN   = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_IDLE  = 3'b100
   } cpr_mode_t;
endpackage

// ===== design/cpr_core_regs.sv
// core operational, status and line power registers
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
// Function
// (RQ1) access to the indirect register goes to the location held in ram select
// (RQ2) jump loads the operand into the low 10 counter bits
// (RQ3) call pushes counter plus one, then loads low 10 bits from operand
// (RQ4) every return reloads the counter from the top of stack
// (RQ5) accumulator write or add to counter clears counter bits 8 and 9
// (RQ6) table lookup adds accumulator, keeping counter bits 8 and 9
// (RQ7) jump, call, add and write load the upper four bits from page select
// (RQ8) status bits 0..2 hold carry, nibble carry and zero from alu results
// (RQ9) power-down bit set at power-on and watchdog clear, cleared by sleep
// (RQ10) time-out bit set at power-up, sleep, watchdog clear; cleared by timeout
// (RQ11) time-out and power-down pair tells the cause of the last wake
// (RQ12) status bit 6 picks the upper io control page; bits 5, 7 unused
// (RQ13) ram select bits 0..5 index, bits 6..7 bank
// (RQ14) page select low four bits give the program page, upper bits unused
// (RQ15) ring and carrier flags read only, 0 means valid
// (RQ16) bit 2 shows demodulated data, meaningful while carrier flag low
// (RQ17) bit 3 powers the demodulator up or down
// (RQ18) bit 4 reads 0 on low supply, 1 when normal
// (RQ19) bit 5 enables the low supply detector
// (RQ20) bit 7 picks idle or full sleep for the sleep instruction
// (RQ21) wake from sleep or idle resumes after the sleep instruction; watchdog or port wake from sleep loads PC_RST instead
// (RQ22) timer, watchdog and port wake react per low-power mode
// (RQ23) bit 6 runs the fast clock, else green mode on the slow clock
// (RQ24) unused bits read zero; read-only bits ignore writes
module cpr_core_regs
   import cpr_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                clkEn,
   // register port
   input  wire logic [3:0]          regAddr,
   input  wire logic [7:0]          regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   output logic      [7:0]          regRdata,
   // data ram behind the indirect register
   input  wire logic [7:0]          ramRdata,
   output logic      [7:0]          ramAddr,
   output logic      [7:0]          ramWdata,
   output logic                     ramWe,
   // program counter control
   input  wire logic [2:0]          pcOp,
   input  wire logic [PC_LO_W-1:0]  pcOperand,
   input  wire logic [7:0]          accum,
   output logic      [PC_W-1:0]     progAddr,
   // alu flags and core events
   input  wire logic                aluFlagWe,
   input  wire logic                aluCarry,
   input  wire logic                aluNibble,
   input  wire logic                aluZero,
   input  wire logic                sleepInstr,
   input  wire logic                wdtClearInstr,
   input  wire logic                wdtTimeout,
   input  wire logic                portWake,
   input  wire logic                resetPinWake,
   input  wire logic                timerTick,
   // line status inputs
   input  wire logic                ringInvalid,
   input  wire logic                carrierInvalid,
   input  wire logic                demodData,
   input  wire logic                supplyNormal,
   // power and mode outputs
   output logic                     ioPage,
   output logic                     demodPowerEn,
   output logic                     lowSupplyDetectEn,
   output logic                     fastClockRun,
   output logic                     slowClockRun,
   output logic                     cpuRun,
   output logic                     timerIrq,
   output logic                     coreResetReq,
   output logic                     wakeResume
);

   // registers
   logic [7:0]       timerCount_reg;
   logic [PC_W-1:0]  pc_reg, pc_next;
   logic             carry_reg, nibble_reg, zero_reg;
   logic             pwrDown_reg, timeOut_reg, ioPage_reg;
   logic [7:0]       ramSel_reg;
   logic [3:0]       page_reg;
   logic [7:0]       lineCtl_reg;
   logic [7:0]       lineIn_reg;
   logic [PC_W-1:0]  stack_reg [STACK_D];
   logic [SP_W-1:0]  sp_reg;
   cpr_mode_t        mode_reg, mode_next;

   // decoded strobes
   logic             wrTimer, wrPc, wrStatus, wrRamSel, wrPage, wrLine;
   logic             timerOvf, running, inSleep, inIdle, doReset, doWake;
   logic [2:0]       op;

   // upper bits from page select with a low part
   function automatic logic [PC_W-1:0] farTarget(
      input logic [3:0]         pg,
      input logic [PC_LO_W-1:0] lo
   );
      farTarget = {pg, lo};
   endfunction

   // low byte plus accumulator, carry out dropped
   function automatic logic [7:0] relAdd(
      input logic [7:0] base,
      input logic [7:0] ofs
   );
      logic [8:0] s;
      s = {1'b0, base} + {1'b0, ofs};
      relAdd = s[7:0];
   endfunction
   // address decode
   assign wrTimer  = regWr && (regAddr == ADDR_TIMER);
   assign wrPc     = regWr && (regAddr == ADDR_PC);
   assign wrStatus = regWr && (regAddr == ADDR_STATUS);
   assign wrRamSel = regWr && (regAddr == ADDR_RAMSEL);
   assign wrPage   = regWr && (regAddr == ADDR_PAGE);
   assign wrLine   = regWr && (regAddr == ADDR_LINE);
   assign running  = (mode_reg == MODE_RUN);
   assign inSleep  = (mode_reg == MODE_SLEEP);
   assign inIdle   = (mode_reg == MODE_IDLE);
   assign timerOvf = timerTick && (timerCount_reg == TIMER_MAX) && !inSleep;
   assign op       = running ? pcOp : PC_HOLD;
   // watchdog or port wake resets in sleep, green and normal
   assign doReset  = (wdtTimeout || portWake) && !inIdle; // RQ22
   // idle wakes on timer, watchdog or port
   assign doWake   = inIdle && (timerOvf || wdtTimeout || portWake); // RQ22

   // low-power state machine
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_RUN:
         begin
            if (sleepInstr && !doReset)
               mode_next = lineCtl_reg[LN_IDLESEL] ? MODE_IDLE : MODE_SLEEP; // RQ20
         end
         MODE_SLEEP:
         begin
            if (doReset || resetPinWake)
               mode_next = MODE_RUN;
         end
         MODE_IDLE:
         begin
            if (doWake)
               mode_next = MODE_RUN; // RQ21
         end
         default:
            mode_next = MODE_RUN;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         mode_reg <= MODE_RUN;
      else if (clkEn)
         mode_reg <= mode_next;
   end

   // program counter next value
   always_comb
   begin
      pc_next = pc_reg;
      case (op)
         PC_STEP:
            pc_next = pc_reg + 14'h0001;
         PC_JUMP:
            pc_next = farTarget(page_reg, pcOperand); // RQ2 RQ7
         PC_CALL:
            pc_next = farTarget(page_reg, pcOperand); // RQ3 RQ7
         PC_RET:
            pc_next = stack_reg[sp_reg - 3'h1]; // RQ4
         PC_MOVA:
            pc_next = farTarget(page_reg, {2'b00, accum}); // RQ5 RQ7
         PC_ADDA:
            pc_next = farTarget(page_reg, {2'b00, relAdd(pc_reg[7:0], accum)}); // RQ5 RQ7
         PC_TABLE:
            pc_next = {pc_reg[PC_W-1:8], relAdd(pc_reg[7:0], accum)}; // RQ6
         default:
            pc_next = pc_reg;
      endcase
      if (wrPc)
         pc_next = farTarget(page_reg, {2'b00, regWdata}); // RQ5 RQ7
      if (doReset)
         pc_next = PC_RST;
   end

   // counter holds across sleep, so idle wakes and reset-pin wake from sleep resume after the sleep instruction
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pc_reg <= PC_RST;
      else if (clkEn)
         pc_reg <= pc_next; // RQ21
   end

   // return stack
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         sp_reg <= '0;
      else if (clkEn)
      begin
         if (doReset)
            sp_reg <= '0;
         else if (op == PC_CALL)
            sp_reg <= sp_reg + 3'h1;
         else if (op == PC_RET)
            sp_reg <= sp_reg - 3'h1;
      end
   end
   always_ff @(posedge clk)
   begin
      if (clkEn && (op == PC_CALL))
         stack_reg[sp_reg] <= pc_reg + 14'h0001; // RQ3
   end

   // timer count
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         timerCount_reg <= TIMER_RST;
      else if (clkEn)
      begin
         if (wrTimer)
            timerCount_reg <= regWdata;
         else if (timerTick && !inSleep)
            timerCount_reg <= timerCount_reg + 8'h01;
      end
   end

   // arithmetic flags and io page
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         carry_reg  <= 1'b0;
         nibble_reg <= 1'b0;
         zero_reg   <= 1'b0;
         ioPage_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         if (wrStatus)
         begin
            carry_reg  <= regWdata[ST_CARRY];
            nibble_reg <= regWdata[ST_NIBBLE];
            zero_reg   <= regWdata[ST_ZERO];
            ioPage_reg <= regWdata[ST_IOPAGE]; // RQ12
         end
         if (aluFlagWe)
         begin
            carry_reg  <= aluCarry; // RQ8
            nibble_reg <= aluNibble; // RQ8
            zero_reg   <= aluZero; // RQ8
         end
      end
   end

   // time-out and power-down, not writable by software
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         timeOut_reg <= 1'b1; // RQ10 RQ11
         pwrDown_reg <= 1'b1; // RQ9 RQ11
      end
      else if (clkEn)
      begin
         if (wdtTimeout)
            timeOut_reg <= 1'b0; // RQ10 RQ11
         else if ((running && (sleepInstr || wdtClearInstr)) || (inSleep && resetPinWake))
            timeOut_reg <= 1'b1; // RQ10 RQ11
         if (running && wdtClearInstr)
            pwrDown_reg <= 1'b1; // RQ9
         else if (running && sleepInstr)
            pwrDown_reg <= 1'b0; // RQ9 RQ11
      end
   end

   // ram select and page select
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ramSel_reg <= RAMSEL_RST;
         page_reg   <= PAGE_RST;
      end
      else if (clkEn)
      begin
         if (wrRamSel)
            ramSel_reg <= regWdata; // RQ13
         if (wrPage)
            page_reg <= regWdata[PAGE_W-1:0]; // RQ14 RQ24
      end
   end

   // line status: writable bits and sampled flags
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lineCtl_reg <= LINE_RST;
         lineIn_reg  <= 8'h00;
      end
      else if (clkEn)
      begin
         if (wrLine)
            lineCtl_reg <= regWdata & LINE_RW_MASK; // RQ17 RQ19 RQ20 RQ23 RQ24
         lineIn_reg <= '0;
         lineIn_reg[LN_RING]    <= ringInvalid; // RQ15
         lineIn_reg[LN_CARRIER] <= carrierInvalid; // RQ15
         lineIn_reg[LN_DATA]    <= demodData; // RQ16
         lineIn_reg[LN_LOWSUP]  <= supplyNormal; // RQ18
      end
   end

   // indirect access to data ram
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ramAddr  <= 8'h00;
         ramWdata <= 8'h00;
         ramWe    <= 1'b0;
      end
      else if (clkEn)
      begin
         ramAddr  <= wrRamSel ? regWdata : ramSel_reg; // RQ1 RQ13
         ramWdata <= regWdata;
         ramWe    <= regWr && (regAddr == ADDR_INDIRECT); // RQ1
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         regRdata <= 8'h00;
      else if (clkEn)
      begin
         regRdata <= 8'h00;
         if (regRd)
         begin
            case (regAddr)
               ADDR_INDIRECT:
                  regRdata <= ramRdata; // RQ1
               ADDR_TIMER:
                  regRdata <= timerCount_reg;
               ADDR_PC:
                  regRdata <= pc_reg[7:0];
               ADDR_STATUS:
                  regRdata <= {1'b0, ioPage_reg, 1'b0, timeOut_reg, pwrDown_reg,
                               zero_reg, nibble_reg, carry_reg}; // RQ8 RQ12 RQ24
               ADDR_RAMSEL:
                  regRdata <= ramSel_reg;
               ADDR_PAGE:
                  regRdata <= {4'h0, page_reg}; // RQ14
               ADDR_LINE:
                  regRdata <= lineCtl_reg | lineIn_reg; // RQ15 RQ16 RQ18
               default:
                  regRdata <= 8'h00;
            endcase
         end
      end
   end

   // clock, run and event outputs
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         progAddr          <= PC_RST;
         ioPage            <= 1'b0;
         demodPowerEn      <= 1'b0;
         lowSupplyDetectEn <= 1'b0;
         fastClockRun      <= 1'b0;
         slowClockRun      <= 1'b1;
         cpuRun            <= 1'b1;
         timerIrq          <= 1'b0;
         coreResetReq      <= 1'b0;
         wakeResume        <= 1'b0;
      end
      else if (clkEn)
      begin
         progAddr          <= pc_next;
         ioPage            <= ioPage_reg; // RQ12
         demodPowerEn      <= lineCtl_reg[LN_DEMODPW]; // RQ17
         lowSupplyDetectEn <= lineCtl_reg[LN_LSDEN]; // RQ19
         fastClockRun      <= lineCtl_reg[LN_FASTCLK] && (mode_next == MODE_RUN); // RQ23
         slowClockRun      <= (mode_next != MODE_SLEEP); // RQ23
         cpuRun            <= (mode_next == MODE_RUN);
         timerIrq          <= timerOvf && !inSleep; // RQ22
         coreResetReq      <= doReset; // RQ22
         wakeResume        <= doWake || (inSleep && resetPinWake); // RQ21
      end
   end

endmodule

// ===== tb/cpr_core_regs_sva.sv
// assertions for the core status and power register bank
`timescale 1ns/1ns
module cpr_core_regs_sva
   import cpr_pkg::*;
(
   // clock and reset
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire logic                clkEn,
   // register port
   input wire logic [3:0]          regAddr,
   input wire logic [7:0]          regWdata,
   input wire logic                regWr,
   input wire logic                regRd,
   input wire logic [7:0]          regRdata,
   // indirect ram
   input wire logic [7:0]          ramWdata,
   input wire logic                ramWe,
   // program counter
   input wire logic [2:0]          pcOp,
   input wire logic [PC_LO_W-1:0]  pcOperand,
   input wire logic [7:0]          accum,
   input wire logic [PC_W-1:0]     progAddr,
   // events and modes
   input wire logic                sleepInstr,
   input wire logic                wdtTimeout,
   input wire logic                portWake,
   input wire logic                ioPage,
   input wire logic                demodPowerEn,
   input wire logic                lowSupplyDetectEn,
   input wire logic                slowClockRun,
   input wire logic                cpuRun,
   input wire logic                coreResetReq,
   input wire logic                wakeResume
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic [3:0] pageCopy_reg;
   logic       idleCopy_reg;
   logic       opOk;

   // copies of page and idle select
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pageCopy_reg <= PAGE_RST;
         idleCopy_reg <= LINE_RST[LN_IDLESEL];
      end
      else if (clkEn && regWr && regAddr == ADDR_PAGE)
         pageCopy_reg <= regWdata[3:0];
      else if (clkEn && regWr && regAddr == ADDR_LINE)
         idleCopy_reg <= regWdata[LN_IDLESEL];
   end

   assign opOk = clkEn && cpuRun && !(regWr && regAddr == ADDR_PC) && !wdtTimeout
      && !portWake && !sleepInstr;

   a_jump_page: assert property (
      opOk && pcOp == PC_JUMP |=> progAddr == {$past(pageCopy_reg), $past(pcOperand)})
      else $error("jump target wrong");
   a_move_acc: assert property (
      opOk && pcOp == PC_MOVA |=> progAddr == {$past(pageCopy_reg), 2'b00, $past(accum)})
      else $error("accumulator move target wrong");
   a_table_keep: assert property (
      opOk && pcOp == PC_TABLE |=>
         progAddr == {$past(progAddr[13:8]), $past(progAddr[7:0] + accum)})
      else $error("table lookup target wrong");
   a_status_read: assert property (
      clkEn && regRd && regAddr == ADDR_STATUS |=>
         !regRdata[7] && !regRdata[5] && regRdata[6] == ioPage)
      else $error("status read wrong");
   a_sleep_mode: assert property (
      clkEn && cpuRun && sleepInstr && !wdtTimeout && !portWake |=>
         !cpuRun && slowClockRun == $past(idleCopy_reg))
      else $error("low power state wrong");
   a_line_enables: assert property (
      clkEn && regWr && regAddr == ADDR_LINE ##1 clkEn |=>
         demodPowerEn == $past(regWdata[3], 2) && lowSupplyDetectEn == $past(regWdata[5], 2))
      else $error("line enables wrong");
   a_indirect_write: assert property (
      clkEn && regWr && regAddr == ADDR_INDIRECT |=> ramWe && ramWdata == $past(regWdata))
      else $error("indirect write lost");
   a_wdt_run: assert property (
      clkEn && cpuRun && wdtTimeout |=> coreResetReq && progAddr == PC_RST)
      else $error("watchdog reset missing");
   a_idle_wake: assert property (
      clkEn && !cpuRun && slowClockRun && (wdtTimeout || portWake) |=>
         cpuRun && wakeResume && !coreResetReq && $stable(progAddr))
      else $error("idle wake wrong");
endmodule

bind cpr_core_regs cpr_core_regs_sva i_cpr_core_regs_sva (.clk, .sys_rst, .clkEn, .regAddr,
   .regWdata, .regWr, .regRd, .regRdata, .ramWdata, .ramWe, .pcOp, .pcOperand, .accum,
   .progAddr, .sleepInstr, .wdtTimeout, .portWake, .ioPage, .demodPowerEn,
   .lowSupplyDetectEn, .slowClockRun, .cpuRun, .coreResetReq, .wakeResume);

// ===== tb/test_core_status_power_regs.sv
// self-checking bench for the core status and power register bank
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin \
      checksDone++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("wrong value at %0t: got %h want %h", $time, got, exp); \
      end \
   end
module test_core_status_power_regs
   import cpr_pkg::*;
   ;
   typedef struct {logic [3:0] a; logic [7:0] d; logic [3:0] lin; logic [7:0] exp;} cpr_row_t;
   localparam logic [9:0] EV_SLEEP = 10'h020, EV_CLR = 10'h010, EV_WDT = 10'h008;
   localparam logic [9:0] EV_PORT = 10'h004, EV_PIN = 10'h002, EV_TICK = 10'h001;
   logic clk, sys_rst, clkEn, regWr, regRd, ramWe, aluFlagWe, aluCarry, aluNibble, aluZero;
   logic sleepInstr, wdtClearInstr, wdtTimeout, portWake, resetPinWake, timerTick;
   logic ringInvalid, carrierInvalid, demodData, supplyNormal, ioPage, demodPowerEn;
   logic lowSupplyDetectEn, fastClockRun, slowClockRun, cpuRun, timerIrq, coreResetReq;
   logic wakeResume;
   logic [3:0] regAddr, lineIn;
   logic [7:0] regWdata, regRdata, ramRdata, ramAddr, ramWdata, accum, rdv;
   logic [2:0] pcOp;
   logic [9:0] pcOperand, evBus;
   logic [13:0] progAddr;
   int cycles, failures, checksDone;
   cpr_row_t rows[9] = '{
      '{ADDR_RAMSEL, 8'ha5, 4'b1011, 8'ha5}, '{ADDR_PAGE, 8'hf3, 4'b1011, 8'h03},
      '{ADDR_STATUS, 8'hff, 4'b1011, 8'h5f}, '{ADDR_STATUS, 8'h00, 4'b1011, 8'h18},
      '{ADDR_LINE, 8'h00, 4'b1011, 8'h15}, '{ADDR_LINE, 8'hff, 4'b0100, 8'hea},
      '{ADDR_LINE, 8'h68, 4'b1011, 8'h7d}, '{4'h7, 8'h55, 4'b1011, 8'h00},
      '{ADDR_TIMER, 8'h3c, 4'b1011, 8'h3c}};

   assign {aluFlagWe, aluCarry, aluNibble, aluZero, sleepInstr, wdtClearInstr, wdtTimeout,
      portWake, resetPinWake, timerTick} = evBus;
   assign {ringInvalid, carrierInvalid, demodData, supplyNormal} = lineIn;

   cpr_core_regs i_cpr_core_regs (.clk, .sys_rst, .clkEn, .regAddr, .regWdata, .regWr,
      .regRd, .regRdata, .ramRdata, .ramAddr, .ramWdata, .ramWe, .pcOp, .pcOperand, .accum,
      .progAddr, .aluFlagWe, .aluCarry, .aluNibble, .aluZero, .sleepInstr, .wdtClearInstr,
      .wdtTimeout, .portWake, .resetPinWake, .timerTick, .ringInvalid, .carrierInvalid,
      .demodData, .supplyNormal, .ioPage, .demodPowerEn, .lowSupplyDetectEn, .fastClockRun,
      .slowClockRun, .cpuRun, .timerIrq, .coreResetReq, .wakeResume);

   always #10 clk = ~clk;

   task automatic giveVerdict;
      $display("checks %0d, failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask

   task automatic ev(input logic [9:0] e);
      @(posedge clk);
      evBus <= e;
      @(posedge clk);
      evBus <= '0;
      #1;
   endtask

   task automatic pcDo(input cpr_pcop_t op, input logic [9:0] o, input logic [7:0] a);
      @(posedge clk);
      pcOp <= op;
      pcOperand <= o;
      accum <= a;
      @(posedge clk);
      pcOp <= PC_HOLD;
      #1;
   endtask

   task automatic tp(input logic [1:0] e);
      logic [7:0] v;
      rd(ADDR_STATUS, v);
      `CHK(v[4:3], e)
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         failures++;
         giveVerdict();
      end
   end

   initial
   begin
      clk = 0; sys_rst = 1; clkEn = 1; regAddr = 0; regWdata = 0; regWr = 0; regRd = 0;
      ramRdata = 8'h6e; pcOp = PC_HOLD; pcOperand = 0; accum = 0; evBus = 0; lineIn = 4'hb;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      tp(2'b11);
      rd(ADDR_LINE, rdv);
      `CHK(rdv, 8'h55)
      `CHK({fastClockRun, cpuRun}, 2'b11)
      foreach (rows[i])
      begin
         @(posedge clk);
         lineIn <= rows[i].lin;
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rdv);
         `CHK(rdv, rows[i].exp)
      end
      `CHK(fastClockRun, 1'b1)
      ev(10'h340);
      rd(ADDR_STATUS, rdv);
      `CHK(rdv[2:0], 3'b101)
      wr(ADDR_PC, 8'h99);
      `CHK(progAddr, 14'h0c99)
      pcDo(PC_JUMP, 10'h2ab, 8'h00);
      `CHK(progAddr, 14'h0eab)
      pcDo(PC_TABLE, 10'h000, 8'h80);
      `CHK(progAddr, 14'h0e2b)
      pcDo(PC_ADDA, 10'h000, 8'h10);
      `CHK(progAddr, 14'h0c3b)
      pcDo(PC_CALL, 10'h012, 8'h00);
      `CHK(progAddr, 14'h0c12)
      pcDo(PC_MOVA, 10'h000, 8'h77);
      `CHK(progAddr, 14'h0c77)
      pcDo(PC_RET, 10'h000, 8'h00);
      `CHK(progAddr, 14'h0c3c)
      pcDo(PC_STEP, 10'h000, 8'h00);
      `CHK(progAddr, 14'h0c3d)
      rd(ADDR_INDIRECT, rdv);
      `CHK(rdv, 8'h6e)
      wr(ADDR_INDIRECT, 8'h3c);
      `CHK({ramWe, ramAddr, ramWdata}, {1'b1, 8'ha5, 8'h3c})
      ev(EV_WDT);
      `CHK({coreResetReq, progAddr}, {1'b1, 14'h0000})
      tp(2'b01);
      ev(EV_CLR);
      tp(2'b11);
      wr(ADDR_TIMER, 8'hff);
      ev(EV_TICK);
      `CHK({timerIrq, cpuRun}, 2'b11)
      wr(ADDR_TIMER, 8'hff);
      ev(EV_SLEEP);
      `CHK({cpuRun, slowClockRun}, 2'b00)
      tp(2'b10);
      ev(EV_TICK);
      `CHK({timerIrq, cpuRun}, 2'b00)
      ev(EV_PIN);
      `CHK({cpuRun, wakeResume}, 2'b11)
      tp(2'b10);
      ev(EV_SLEEP);
      ev(EV_WDT);
      `CHK(coreResetReq, 1'b1)
      tp(2'b00);
      wr(ADDR_LINE, 8'he8);
      wr(ADDR_PAGE, 8'h03);
      pcDo(PC_JUMP, 10'h055, 8'h00);
      ev(EV_SLEEP);
      `CHK({cpuRun, slowClockRun}, 2'b01)
      ev(EV_PORT);
      `CHK({cpuRun, wakeResume, coreResetReq, progAddr}, {3'b110, 14'h0c55})
      wr(ADDR_TIMER, 8'hff);
      ev(EV_SLEEP);
      ev(EV_TICK);
      `CHK({cpuRun, wakeResume, timerIrq}, 3'b111)
      @(posedge clk);
      clkEn <= 1'b0;
      wr(ADDR_RAMSEL, 8'h22);
      @(posedge clk);
      clkEn <= 1'b1;
      rd(ADDR_RAMSEL, rdv);
      `CHK({rdv, ramAddr}, {8'ha5, 8'ha5})
      giveVerdict();
   end
endmodule
